/* core/pfd_pkg.sv */
package pfd_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_TARGET = 4'hC;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_NOP_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam int ST_RSV_BIT = 0;
   localparam int ST_ISSUE_BIT = 1;
   localparam int ST_W = 2;
   // ****************************************
   // instruction classes from fetch
   // ****************************************
   localparam logic [3:0] CLS_PC_RELATIVE_GROUP = 4'h0;
   localparam logic [3:0] CLS_SDPS = 4'h1;
   localparam logic [3:0] CLS_SD1 = 4'h2;
   localparam logic [3:0] CLS_SD2 = 4'h3;
   localparam logic [3:0] CLS_SWL = 4'h4;
   localparam logic [3:0] CLS_DWL = 4'h5;
   localparam logic [3:0] CLS_BRANCH = 4'h6;
   localparam logic [3:0] CLS_JUMP = 4'h7;
   // ****************************************
   // field positions in the assembled word
   // ****************************************
   localparam int MINOR_HI = 20;
   localparam int MINOR_LO = 18;
   localparam int EXT_HI = 17;
   localparam int EXT_LO = 16;
   localparam int FMT_HI = 14;
   localparam int FMT_LO = 13;
   localparam int BOFF_HI = 15;
   localparam int JIDX_HI = 25;
   localparam int REGION_LO = 27;
   localparam logic [2:0] MINOR_UPPER = 3'h7;
   localparam logic [2:0] MINOR_COUNTER_RELATIVE_DOUBLEWORD_LOAD = 3'h6;
   localparam logic [1:0] EXT_AUI = 2'h2;
   localparam logic [1:0] EXT_ALUI = 2'h3;
   localparam logic [31:0] INSN_BYTES = 32'h4;
   // ****************************************
   // decoded operations and formats
   // ****************************************
   typedef enum logic [3:0] {
      OP_NONE, OP_ADD_IMM, OP_WORD_LOAD, OP_UWORD_LOAD, OP_DWORD_LOAD,
      OP_UPPER_ADD, OP_ALIGNED_UPPER_ADD, OP_FP, OP_BRANCH, OP_JUMP_AND_LINK
   } pfd_op_e;
   typedef enum logic [2:0] {
      FMT_NONE, FMT_SINGLE, FMT_DOUBLE, FMT_PAIRED, FMT_WORD, FMT_LONG
   } pfd_fmt_e;
endpackage

/* core/pfd_decode.sv */
`timescale 1ns/10ps
// Behaviour
// - pc-relative bits 20..18 pick add-immediate, word, unsigned word or doubleword load.
// - minor 111 uses bits 17..16: 10 upper add, 11 aligned, 00/01 unassigned.
// - single/double/paired set: 0 single, 1 double, 2 paired, 3 reserved.
// - one-bit single/double field: 0 single, 1 double.
// - two-bit single/double field: 0 single, 1 double, 2 and 3 reserved.
// - single/word/long set: 0 single, 1 word, 2 long, 3 reserved.
// - double/word/long set: 0 double, 1 word, 2 long, 3 reserved.
// - reserved encodings raise an exception or retire as no operation.
// - branch targets are halfword aligned.
// - jump target stays in the current 128 MB region, halfword aligned.
// - branch-likely operations are not decoded; their classes are reserved.
// - branch and jump offsets shift left by one bit.
// - halves of one instruction may arrive apart, across line or page edges.
module pfd_decode (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic FETCH_VALID,
   input wire logic FETCH_FIRST,
   input wire logic [15:0] FETCH_HALF,
   input wire logic [3:0] FETCH_CLASS,
   input wire logic [31:0] FETCH_PC,
   output logic OP_VALID,
   output logic [3:0] OP_CODE,
   output logic [2:0] OP_FMT,
   output logic [31:0] OP_TARGET,
   output logic RSV_EXC,
   output logic IRQ,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);
   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta_q, rst_n;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ****************************************
   // halfword assembly
   // ****************************************
   typedef enum logic {ST_IDLE, ST_HAVE_HI} pfd_state_e;
   pfd_state_e st_q, st_d;
   logic [15:0] hi_q, hi_d;
   logic [3:0] cls_q, cls_d;
   logic [31:0] pc_q, pc_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic take_hi, take_lo, rsv;
   logic [31:0] word;

   assign take_hi = FETCH_VALID && FETCH_FIRST && ctrl_q[pfd_pkg::CTRL_EN_BIT]
                    && (st_q == ST_IDLE);
   assign take_lo = FETCH_VALID && ctrl_q[pfd_pkg::CTRL_EN_BIT] && (st_q == ST_HAVE_HI);
   assign word = {hi_q, FETCH_HALF};

   always_comb begin
      st_d = st_q;
      hi_d = hi_q;
      cls_d = cls_q;
      pc_d = pc_q;
      // second half may come any number of cycles later
      if (take_hi) begin
         st_d = ST_HAVE_HI;
         hi_d = FETCH_HALF;
         cls_d = FETCH_CLASS;
         pc_d = FETCH_PC;
      end else if (take_lo) begin
         st_d = ST_IDLE;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         hi_q <= 16'h0000;
         cls_q <= 4'h0;
         pc_q <= 32'h00000000;
      end else begin
         st_q <= st_d;
         hi_q <= hi_d;
         cls_q <= cls_d;
         pc_q <= pc_d;
      end
   end

   // ****************************************
   // decode
   // ****************************************
   pfd_pkg::pfd_op_e op;
   pfd_pkg::pfd_fmt_e fmt;
   logic [31:0] tgt;
   logic [2:0] minor;
   logic [1:0] ext, fmt2;

   assign minor = word[pfd_pkg::MINOR_HI:pfd_pkg::MINOR_LO];
   assign ext = word[pfd_pkg::EXT_HI:pfd_pkg::EXT_LO];
   assign fmt2 = word[pfd_pkg::FMT_HI:pfd_pkg::FMT_LO];

   always_comb begin
      op = pfd_pkg::OP_FP;
      fmt = pfd_pkg::FMT_NONE;
      rsv = 1'b0;
      tgt = 32'h00000000;
      case (cls_q)
         pfd_pkg::CLS_PC_RELATIVE_GROUP: begin
            tgt = pc_q;
            case (minor)
               3'h0, 3'h1: op = pfd_pkg::OP_ADD_IMM;
               3'h2, 3'h3: op = pfd_pkg::OP_WORD_LOAD;
               3'h4, 3'h5: op = pfd_pkg::OP_UWORD_LOAD;
               pfd_pkg::MINOR_COUNTER_RELATIVE_DOUBLEWORD_LOAD: op = pfd_pkg::OP_DWORD_LOAD;
               default: begin
                  if (ext == pfd_pkg::EXT_AUI) begin
                     op = pfd_pkg::OP_UPPER_ADD;
                  end else if (ext == pfd_pkg::EXT_ALUI) begin
                     op = pfd_pkg::OP_ALIGNED_UPPER_ADD;
                  end else begin
                     op = pfd_pkg::OP_NONE;
                     rsv = 1'b1;
                  end
               end
            endcase
         end
         pfd_pkg::CLS_SDPS: begin
            case (fmt2)
               2'h0: fmt = pfd_pkg::FMT_SINGLE;
               2'h1: fmt = pfd_pkg::FMT_DOUBLE;
               2'h2: fmt = pfd_pkg::FMT_PAIRED;
               default: rsv = 1'b1;
            endcase
         end
         pfd_pkg::CLS_SD1: begin
            fmt = word[pfd_pkg::FMT_LO] ? pfd_pkg::FMT_DOUBLE : pfd_pkg::FMT_SINGLE;
         end
         pfd_pkg::CLS_SD2: begin
            case (fmt2)
               2'h0: fmt = pfd_pkg::FMT_SINGLE;
               2'h1: fmt = pfd_pkg::FMT_DOUBLE;
               default: rsv = 1'b1;
            endcase
         end
         pfd_pkg::CLS_SWL, pfd_pkg::CLS_DWL: begin
            case (fmt2)
               2'h0: begin
                  fmt = (cls_q == pfd_pkg::CLS_SWL) ? pfd_pkg::FMT_SINGLE : pfd_pkg::FMT_DOUBLE;
               end
               2'h1: fmt = pfd_pkg::FMT_WORD;
               2'h2: fmt = pfd_pkg::FMT_LONG;
               default: rsv = 1'b1;
            endcase
         end
         pfd_pkg::CLS_BRANCH: begin
            op = pfd_pkg::OP_BRANCH;
            // halfword aligned, offset doubled
            tgt = pc_q + pfd_pkg::INSN_BYTES +
                  {{15{word[pfd_pkg::BOFF_HI]}}, word[pfd_pkg::BOFF_HI:0], 1'b0};
         end
         pfd_pkg::CLS_JUMP: begin
            op = pfd_pkg::OP_JUMP_AND_LINK;
            tgt = {pc_q[31:pfd_pkg::REGION_LO], word[pfd_pkg::JIDX_HI:0], 1'b0};
         end
         default: begin
            // branch-likely and other unassigned classes
            op = pfd_pkg::OP_NONE;
            rsv = 1'b1;
         end
      endcase
      if (rsv) begin
         op = pfd_pkg::OP_NONE;
         fmt = pfd_pkg::FMT_NONE;
      end
   end

   // ****************************************
   // issue stage
   // ****************************************
   logic op_valid_d, rsv_exc_d, nop_mode;
   logic [3:0] op_code_d;
   logic [2:0] op_fmt_d;
   logic [31:0] op_target_d;

   assign nop_mode = ctrl_q[pfd_pkg::CTRL_NOP_BIT];

   always_comb begin
      op_valid_d = 1'b0;
      rsv_exc_d = 1'b0;
      op_code_d = OP_CODE;
      op_fmt_d = OP_FMT;
      op_target_d = OP_TARGET;
      if (take_lo) begin
         op_code_d = op;
         op_fmt_d = fmt;
         op_target_d = tgt;
         // reserved: exception, or a retiring no operation
         op_valid_d = !rsv || nop_mode;
         rsv_exc_d = rsv && !nop_mode;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         OP_VALID <= 1'b0;
         RSV_EXC <= 1'b0;
         OP_CODE <= 4'h0;
         OP_FMT <= 3'h0;
         OP_TARGET <= 32'h00000000;
      end else begin
         OP_VALID <= op_valid_d;
         RSV_EXC <= rsv_exc_d;
         OP_CODE <= op_code_d;
         OP_FMT <= op_fmt_d;
         OP_TARGET <= op_target_d;
      end
   end

   // ****************************************
   // register slave and interrupt
   // ****************************************
   logic [pfd_pkg::ST_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
   logic wait_d, irq_d, acc_rd, acc_wr;
   logic [31:0] rdata_d;

   assign acc_rd = AVS_READ && !AVS_WAITREQUEST;
   assign acc_wr = AVS_WRITE && !AVS_WAITREQUEST;
   assign ev = {op_valid_d && (op_code_d != pfd_pkg::OP_NONE), rsv && take_lo};

   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      stat_d = stat_q;
      rdata_d = AVS_READDATA;
      // one wait cycle, then a single low cycle
      wait_d = !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
         rdata_d = 32'h00000000;
         if (AVS_ADDRESS == pfd_pkg::REG_CTRL) begin
            rdata_d[1:0] = ctrl_q;
         end else if (AVS_ADDRESS == pfd_pkg::REG_STATUS) begin
            rdata_d[pfd_pkg::ST_W-1:0] = stat_q;
         end else if (AVS_ADDRESS == pfd_pkg::REG_MASK) begin
            rdata_d[pfd_pkg::ST_W-1:0] = mask_q;
         end else if (AVS_ADDRESS == pfd_pkg::REG_TARGET) begin
            rdata_d = OP_TARGET;
         end
      end
      if (acc_wr) begin
         if (AVS_ADDRESS == pfd_pkg::REG_CTRL) begin
            ctrl_d = AVS_WRITEDATA[1:0];
         end else if (AVS_ADDRESS == pfd_pkg::REG_MASK) begin
            mask_d = AVS_WRITEDATA[pfd_pkg::ST_W-1:0];
         end
      end
      if (acc_rd && (AVS_ADDRESS == pfd_pkg::REG_STATUS)) begin
         stat_d = stat_q & ~AVS_READDATA[pfd_pkg::ST_W-1:0]; // clear only bits returned
      end
      // new event beats the read clear
      stat_d = stat_d | ev;
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= pfd_pkg::CTRL_RESET;
         mask_q <= '0;
         stat_q <= '0;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h00000000;
         IRQ <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         AVS_WAITREQUEST <= wait_d;
         AVS_READDATA <= rdata_d;
         IRQ <= irq_d;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   sequence seq_pc_relative_group(logic [2:0] m);
      take_lo && (cls_q == pfd_pkg::CLS_PC_RELATIVE_GROUP) && (minor == m);
   endsequence
   sequence seq_fmt(logic [3:0] c, logic [1:0] f);
      take_lo && (cls_q == c) && (fmt2 == f);
   endsequence

   pc_relative_group_load_a: assert property (seq_pc_relative_group(3'h3) |=> OP_VALID
      && (OP_CODE == pfd_pkg::OP_WORD_LOAD)) else $error("word load misdecoded");
   pc_relative_group_dword_a: assert property (seq_pc_relative_group(pfd_pkg::MINOR_COUNTER_RELATIVE_DOUBLEWORD_LOAD) |=> OP_VALID
      && (OP_CODE == pfd_pkg::OP_DWORD_LOAD)) else $error("doubleword load misdecoded");
   upper_add_a: assert property (
      seq_pc_relative_group(pfd_pkg::MINOR_UPPER) ##0 (ext == pfd_pkg::EXT_ALUI)
      |=> (OP_CODE == pfd_pkg::OP_ALIGNED_UPPER_ADD)) else $error("aligned upper misdecoded");
   unassigned_a: assert property (
      seq_pc_relative_group(pfd_pkg::MINOR_UPPER) ##0 (!ext[1] && !nop_mode)
      |=> RSV_EXC && !OP_VALID) else $error("unassigned encoding issued");
   paired_fmt_a: assert property (seq_fmt(pfd_pkg::CLS_SDPS, 2'h2)
      |=> OP_VALID && (OP_FMT == pfd_pkg::FMT_PAIRED)) else $error("paired format wrong");
   one_bit_a: assert property (take_lo && (cls_q == pfd_pkg::CLS_SD1)
      |=> (OP_FMT == ($past(word[pfd_pkg::FMT_LO]) ? pfd_pkg::FMT_DOUBLE
      : pfd_pkg::FMT_SINGLE))) else $error("one-bit format wrong");
   sd2_rsv_a: assert property (take_lo && (cls_q == pfd_pkg::CLS_SD2) && fmt2[1]
      |=> (RSV_EXC != OP_VALID)) else $error("reserved format not trapped");
   long_fmt_a: assert property (
      seq_fmt(pfd_pkg::CLS_SWL, 2'h2) or seq_fmt(pfd_pkg::CLS_DWL, 2'h2)
      |=> (OP_FMT == pfd_pkg::FMT_LONG)) else $error("long format wrong");
   dwl_double_a: assert property (seq_fmt(pfd_pkg::CLS_DWL, 2'h0)
      |=> (OP_FMT == pfd_pkg::FMT_DOUBLE)) else $error("double format wrong");
   nop_mode_a: assert property (take_lo && rsv && nop_mode
      |=> OP_VALID && !RSV_EXC && (OP_CODE == pfd_pkg::OP_NONE)) else $error("nop mode broken");
   branch_tgt_a: assert property (take_lo && (cls_q == pfd_pkg::CLS_BRANCH)
      |=> !OP_TARGET[0] && (OP_TARGET == $past(pc_q) + pfd_pkg::INSN_BYTES
      + {{15{$past(word[15])}}, $past(word[15:0]), 1'b0})) else $error("branch target wrong");
   jump_region_a: assert property (take_lo && (cls_q == pfd_pkg::CLS_JUMP) |=>
      (OP_TARGET[31:27] == $past(pc_q[31:27])) && (OP_TARGET[26:1] == $past(word[25:0])))
      else $error("jump left region");
   straddle_a: assert property (take_hi ##1 (!FETCH_VALID)[*3] ##1 take_lo
      |=> (OP_VALID || RSV_EXC)) else $error("split instruction lost");
   likely_a: assert property (take_lo && cls_q[3] && !nop_mode |=> RSV_EXC)
      else $error("unassigned class issued");
endmodule

/* tb/pfd_fetch_model.sv */
`timescale 1ns/10ps
module pfd_fetch_model (
   input wire logic clk,
   output logic valid,
   output logic first,
   output logic [15:0] half,
   output logic [3:0] cls,
   output logic [31:0] pc
);
   initial begin
      valid = 1'b0;
      first = 1'b0;
      half = 16'h0;
      cls = 4'h0;
      pc = 32'h0;
   end
   // ****************************************
   // upper half first, optional gap, lower half
   // ****************************************
   task automatic send(input logic [31:0] w, input logic [3:0] c, input logic [31:0] a,
         input int gap);
      @(posedge clk);
      valid <= 1'b1;
      first <= 1'b1;
      half <= w[31:16];
      cls <= c;
      pc <= a;
      repeat (gap) begin
         @(posedge clk);
         valid <= 1'b0;
         first <= 1'b0;
         half <= ~w[31:16];
      end
      @(posedge clk);
      valid <= 1'b1;
      first <= 1'b0;
      half <= w[15:0];
      cls <= ~c;
      pc <= ~a;
      @(posedge clk);
      valid <= 1'b0;
      half <= ~w[15:0];
   endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic clk;
   logic rst_n;
   logic f_valid;
   logic f_first;
   logic [15:0] f_half;
   logic [3:0] f_cls;
   logic [31:0] f_pc;
   logic op_valid;
   logic [3:0] op_code;
   logic [2:0] op_fmt;
   logic [31:0] op_tgt;
   logic rsv_exc;
   logic irq;
   logic [3:0] av_addr;
   logic av_rd;
   logic av_wr;
   logic [31:0] av_wdata;
   logic [31:0] av_rdata;
   logic av_wait;
   logic [31:0] q;
   int err_count;
   int checks;
   pfd_decode dut_u (.CLK(clk), .RESETN(rst_n), .FETCH_VALID(f_valid), .FETCH_FIRST(f_first),
      .FETCH_HALF(f_half), .FETCH_CLASS(f_cls), .FETCH_PC(f_pc), .OP_VALID(op_valid),
      .OP_CODE(op_code), .OP_FMT(op_fmt), .OP_TARGET(op_tgt), .RSV_EXC(rsv_exc), .IRQ(irq),
      .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata),
      .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait));
   pfd_fetch_model fetch_u (.clk(clk), .valid(f_valid), .first(f_first), .half(f_half),
      .cls(f_cls), .pc(f_pc));
   always #5 clk = ~clk;
   // ****************************************
   // report helpers
   // ****************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // avalon master
   // ****************************************
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      av_rd <= ~wr;
      av_wr <= wr;
      av_addr <= a;
      av_wdata <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (av_wait === 1'b0) begin
            q = av_rdata;
            break;
         end
      end
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (n == 20) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk("register", q, exp);
   endtask
   // ****************************************
   // one instruction through the decoder
   // ****************************************
   task automatic run(input logic [31:0] w, input logic [3:0] c, input logic [31:0] a,
         input int gap, input logic rsv, input logic [3:0] code, input logic [2:0] fmt,
         input logic [31:0] tgt, input logic full);
      int n;
      fetch_u.send(w, c, a, gap);
      for (n = 0; n < 8; n++) begin
         @(posedge clk);
         if (op_valid === 1'b1 || rsv_exc === 1'b1) begin
            break;
         end
      end
      if (n == 8) begin
         err_count++;
         conclude();
      end
      chk("latency", n, 0);
      chk("exception", 32'(rsv_exc), 32'(rsv));
      chk("issue", 32'(op_valid), 32'(!rsv));
      if (!rsv) begin
         chk("op", 32'(op_code), 32'(code));
      end
      if (!rsv && full) begin
         chk("fmt", 32'(op_fmt), 32'(fmt));
         chk("target", op_tgt, tgt);
      end
   endtask
   function automatic logic [4:0] pc_op(input int m, input int e);
      case (m)
         0, 1: pc_op = {1'b0, pfd_pkg::OP_ADD_IMM};
         2, 3: pc_op = {1'b0, pfd_pkg::OP_WORD_LOAD};
         4, 5: pc_op = {1'b0, pfd_pkg::OP_UWORD_LOAD};
         6: pc_op = {1'b0, pfd_pkg::OP_DWORD_LOAD};
         default: pc_op = e == 2 ? {1'b0, pfd_pkg::OP_UPPER_ADD} :
               e == 3 ? {1'b0, pfd_pkg::OP_ALIGNED_UPPER_ADD} : 5'h10;
      endcase
   endfunction
   function automatic logic [2:0] fp_fmt(input int c, input int f);
      logic [2:0] t [0:19];
      t = '{1, 2, 3, 0, 1, 2, 0, 0, 1, 2, 0, 0, 1, 4, 5, 0, 2, 4, 5, 0};
      fp_fmt = t[(c - 1) * 4 + f];
   endfunction
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_addr = 4'h0;
      av_wdata = 32'h0;
      err_count = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(pfd_pkg::REG_CTRL, 32'h1);
      rdc(pfd_pkg::REG_STATUS, 32'h0);
      rdc(pfd_pkg::REG_MASK, 32'h0);
      rdc(4'h2, 32'h0);
      bus(1'b1, pfd_pkg::REG_MASK, 32'h3);
      rdc(pfd_pkg::REG_MASK, 32'h3);
      bus(1'b1, pfd_pkg::REG_MASK, 32'h0);
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         for (int e = 0; e < 4; e++) begin
            run((m << 18) | (e << 16), pfd_pkg::CLS_PC_RELATIVE_GROUP,
               32'h400000 + m * 8 + e * 2, e, 1'(pc_op(m, e) >> 4), 4'(pc_op(m, e)),
               pfd_pkg::FMT_NONE, 32'h400000 + m * 8 + e * 2, 1'b1);
         end
      end
      rdc(pfd_pkg::REG_STATUS, 32'h3);
      rdc(pfd_pkg::REG_STATUS, 32'h0);
      $display("test pc relative done");
      for (int c = 1; c < 6; c++) begin
         for (int f = 0; f < (c == 2 ? 2 : 4); f++) begin
            run(f << 13, 4'(c), 32'h100, 0, fp_fmt(c, f) == 0,
               pfd_pkg::OP_FP, fp_fmt(c, f), 32'h0, 1'b1);
         end
      end
      $display("test formats done");
      run(32'h3, pfd_pkg::CLS_BRANCH, 32'h10000002, 2, 0,
         pfd_pkg::OP_BRANCH, 0, 32'h1000000C, 1);
      run(32'hFFFF, pfd_pkg::CLS_BRANCH, 32'h2000, 0, 0,
         pfd_pkg::OP_BRANCH, 0, 32'h2002, 1);
      run(32'h3FFFFFF, pfd_pkg::CLS_JUMP, 32'hE8001234, 1, 0,
         pfd_pkg::OP_JUMP_AND_LINK, 0, 32'hEFFFFFFE, 1);
      rdc(pfd_pkg::REG_TARGET, 32'hEFFFFFFE);
      rdc(pfd_pkg::REG_STATUS, 32'h3);
      $display("test targets done");
      bus(1'b1, pfd_pkg::REG_MASK, 32'h1);
      for (int c = 8; c < 16; c++) begin
         run(32'h0, 4'(c), 32'h200, 0, 1, 0, 0, 0, 0);
      end
      chk("irq", 32'(irq), 32'h1);
      rdc(pfd_pkg::REG_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq", 32'(irq), 32'h0);
      run(32'h4, pfd_pkg::CLS_BRANCH, 32'h0, 0, 0, pfd_pkg::OP_BRANCH, 0, 32'hC, 1);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'(irq), 32'h0);
      $display("test interrupt done");
      bus(1'b1, pfd_pkg::REG_CTRL, 32'h3);
      rdc(pfd_pkg::REG_STATUS, 32'h2);
      run(32'h0, 4'h9, 32'h0, 0, 0, pfd_pkg::OP_NONE, 0, 0, 0);
      rdc(pfd_pkg::REG_STATUS, 32'h1);
      bus(1'b1, pfd_pkg::REG_CTRL, 32'h0);
      fetch_u.send(32'h4, pfd_pkg::CLS_BRANCH, 32'h0, 0);
      repeat (3) begin
         @(posedge clk);
         chk("idle", 32'(op_valid | rsv_exc), 32'h0);
      end
      $display("test modes done");
      conclude();
   end
endmodule
